// ===== vpwc_pkg.sv
package vpwc_pkg;
  localparam int CLK_HZ       = 40_000_000;
  localparam int CLK_NS       = 25;
  // Nominal symbol lengths in microseconds at 10.4 kbps
  localparam int SHORT_US     = 64;
  localparam int LONG_US      = 128;
  localparam int SOF_US       = 200;
  localparam int EOD_US       = 200;
  localparam int EOF_US       = 280;
  localparam int EOF_EXT_US   = 80;
  localparam int IFS_EXT_US   = 20;
  localparam int IFS_US       = 300;
  localparam int BREAK_US     = 240;
  localparam int CNT_W        = 16;
  localparam int SHORT_CYC    = SHORT_US * 1000 / CLK_NS;
  localparam int LONG_CYC     = LONG_US * 1000 / CLK_NS;
  localparam int SOF_CYC      = SOF_US * 1000 / CLK_NS;
  localparam int EOD_CYC      = EOD_US * 1000 / CLK_NS;
  localparam int EOF_CYC      = EOF_US * 1000 / CLK_NS;
  localparam int IFS_CYC      = IFS_US * 1000 / CLK_NS;
  localparam int BREAK_CYC    = (BREAK_US * 1000 + CLK_NS - 1) / CLK_NS;
  // Default receive limits; LIM_B, LIM_C and LIM_F midway between nominal lengths
  localparam int LIM_A_CYC    = 34 * 1000 / CLK_NS;
  localparam int LIM_B_CYC    = 96 * 1000 / CLK_NS;
  localparam int LIM_C_CYC    = 164 * 1000 / CLK_NS;
  localparam int LIM_D_CYC    = 239 * 1000 / CLK_NS;
  localparam int LIM_E_CYC    = 240 * 1000 / CLK_NS;
  localparam int LIM_F_CYC    = 290 * 1000 / CLK_NS;

  typedef enum logic [3:0] {
    VPWC_SYM_NONE, VPWC_SYM_ZERO, VPWC_SYM_ONE, VPWC_SYM_SOF,
    VPWC_SYM_EOD, VPWC_SYM_EOF, VPWC_SYM_IFS, VPWC_SYM_BREAK,
    VPWC_SYM_INVALID, VPWC_SYM_IDLE
  } vpwc_sym_t;

  typedef enum logic [1:0] {
    VPWC_TX_DATA0, VPWC_TX_DATA1, VPWC_TX_SOF, VPWC_TX_EOD
  } vpwc_txk_t;
endpackage : vpwc_pkg

// ===== vpwc_rx_if.sv
`timescale 1ns/100ps
interface vpwc_rx_if;
  import vpwc_pkg::*;
  logic                  edge_seen;
  logic                  level_active;
  logic [CNT_W-1:0]      elapsed;
  modport src (output edge_seen, output level_active, output elapsed);
  modport dst (input edge_seen, input level_active, input elapsed);
endinterface : vpwc_rx_if

// ===== vpwc_rx_timer.sv
`timescale 1ns/100ps
module vpwc_rx_timer (
  input  wire logic  clk,
  input  wire logic  rstn,
  input  wire logic  bus_rx,
  vpwc_rx_if.src     tm
);
  import vpwc_pkg::*;
  logic                  sync1;
  logic                  sync2;
  logic                  prev;
  logic [CNT_W-1:0]      cnt;
  wire                   is_edge = sync2 != prev;
  wire [CNT_W-1:0]       next_cnt = (&cnt) ? cnt : cnt + 1'b1;

  // Pin crosses two flops before any decision
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      sync1 <= 1'b0;
      sync2 <= 1'b0;
      prev  <= 1'b0;
    end else begin
      sync1 <= bus_rx;
      sync2 <= sync1;
      prev  <= sync2;
    end
  end

  // Length counted in whole clock periods; saturates on idle [R13]
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) cnt <= '0;
    else if (is_edge) cnt <= CNT_W'(1);
    else cnt <= next_cnt;
  end

  assign tm.edge_seen    = is_edge;
  assign tm.level_active = prev;
  assign tm.elapsed      = cnt;
endmodule : vpwc_rx_timer

// ===== vpwc_codec.sv
// Functional notes
// R1 - Level and duration between edges encode bits
// R2 - One edge per bit, 64 or 128 us
// R3 - First bit of each byte is passive
// R4 - Zero: passive 64 or active 128
// R5 - One: passive 128 or active 64
// R6 - Normalization bit coded as ordinary bit
// R7 - BREAK is active for at least 240 us
// R8 - SOF is active 200 us
// R9 - EOD is passive 200 us
// R10 - EOF passive 280 us, EOD plus 80
// R11 - IFS totals 300 us passive
// R12 - Passive over 300 us means idle
// R13 - Durations counted in whole clock periods
// R14 - Receive windows abut without gaps
// R15 - Passive interval classified by ascending windows
// R16 - Active interval classified by ascending windows
// R17 - Active past last limit is BREAK
// R18 - Late start edge gives EOF or IFS
// R19 - Pending send waits IFS, edge after EOF
// R20 - No start edge by last limit: idle
// R21 - BREAK sender should follow with SOF
// R22 - Device never sends BREAK; halts on one
// R23 - BREAK while receiving is an error
// R24 - Receive limits are configurable counts
`timescale 1ns/100ps
module vpwc_codec #(
  parameter int LIM_A = vpwc_pkg::LIM_A_CYC, // [R24]
  parameter int LIM_B = vpwc_pkg::LIM_B_CYC,
  parameter int LIM_C = vpwc_pkg::LIM_C_CYC,
  parameter int LIM_D = vpwc_pkg::LIM_D_CYC,
  parameter int LIM_E = vpwc_pkg::LIM_E_CYC,
  parameter int LIM_F = vpwc_pkg::LIM_F_CYC,
  parameter int LIM_G = vpwc_pkg::IFS_CYC
) (
  input  wire logic               clk,
  input  wire logic               rstn,
  input  wire logic               bus_rx,
  output logic                    bus_tx_active,
  input  wire logic               tx_valid,
  input  wire vpwc_pkg::vpwc_txk_t tx_kind,
  output logic                    tx_ready,
  output logic                    tx_pending,
  input  wire logic               tx_abort,
  output logic                    tx_halted,
  output logic                    rx_valid,
  output vpwc_pkg::vpwc_sym_t     rx_sym,
  output logic                    bus_idle
);
  import vpwc_pkg::*;

  vpwc_rx_if tm ();
  vpwc_rx_timer u_timer (
    .clk    (clk),
    .rstn   (rstn),
    .bus_rx (bus_rx),
    .tm     (tm)
  );

  localparam logic [CNT_W-1:0] LA = CNT_W'(LIM_A);
  localparam logic [CNT_W-1:0] LB = CNT_W'(LIM_B);
  localparam logic [CNT_W-1:0] LC = CNT_W'(LIM_C);
  localparam logic [CNT_W-1:0] LD = CNT_W'(LIM_D);
  localparam logic [CNT_W-1:0] LE = CNT_W'(LIM_E);
  localparam logic [CNT_W-1:0] LF = CNT_W'(LIM_F);
  localparam logic [CNT_W-1:0] LG = CNT_W'(LIM_G);

  // Window upper limits double as next lower limits, so no gaps [R14]
  function automatic vpwc_sym_t classify(input logic act,
                                         input logic [CNT_W-1:0] n);
    if (n < LA) return VPWC_SYM_INVALID;
    if (!act) begin // [R15]
      if (n < LB) return VPWC_SYM_ZERO; // [R4]
      if (n < LC) return VPWC_SYM_ONE; // [R5]
      if (n < LD) return VPWC_SYM_EOD; // [R9]
      if (n < LF) return VPWC_SYM_EOF; // [R18]
      return VPWC_SYM_IFS; // [R18]
    end
    if (n < LB) return VPWC_SYM_ONE; // [R16]
    if (n < LC) return VPWC_SYM_ZERO;
    if (n <= LD) return VPWC_SYM_SOF; // [R8]
    return VPWC_SYM_BREAK; // [R17]
  endfunction : classify

  wire        was_active = tm.level_active;
  wire [CNT_W-1:0] n     = tm.elapsed;
  // Edge ends the interval just measured; polarity before the edge
  wire        done_active = was_active;
  wire vpwc_sym_t edge_sym = classify(done_active, n - 1'b1); // [R1]
  // Break and idle are flagged while the level still stands
  wire        hit_break = was_active && !tm.edge_seen && n == LE; // [R7]
  wire        hit_idle  = !was_active && !tm.edge_seen && n == LG; // [R12]
  wire        eof_seen  = !was_active && n >= LD; // [R10]
  wire        ifs_done  = !was_active && n >= LG; // [R11]

  // Tx symbol timer and level
  logic [CNT_W-1:0] tx_cnt;
  logic             tx_busy;
  logic             eof_armed;
  logic             tx_level;
  wire  logic       next_level;
  wire [CNT_W-1:0]  next_len;
  wire              is_sof = tx_kind == VPWC_TX_SOF;
  // Each bit toggles the level; SOF forces active, EOD passive [R2]
  // so the first bit after SOF always goes out passive [R3]
  assign next_level = is_sof ? 1'b1 :
                      (tx_kind == VPWC_TX_EOD) ? 1'b0 : ~tx_level;
  // Passive zero and active one short; else long [R4] [R5] [R6]
  assign next_len = is_sof ? CNT_W'(SOF_CYC) :
                    (tx_kind == VPWC_TX_EOD) ? CNT_W'(EOD_CYC) :
                    ((tx_kind == VPWC_TX_DATA1) == next_level) ?
                      CNT_W'(SHORT_CYC) : CNT_W'(LONG_CYC);
  // SOF waits for IFS or idle, or any start edge once EOF seen [R19] [R20]
  wire sof_go  = ifs_done || bus_idle ||
                 (eof_armed && tm.edge_seen && !was_active);
  wire can_go  = !tx_busy && !tx_halted && tx_valid &&
                 (!is_sof || sof_go);
  wire tx_fire = can_go && !tx_abort;

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      bus_tx_active <= 1'b0;
      tx_level      <= 1'b0;
      tx_cnt        <= '0;
      tx_busy       <= 1'b0;
    end else if (tx_abort || tx_halted) begin
      bus_tx_active <= 1'b0;
      tx_level      <= 1'b0;
      tx_busy       <= 1'b0;
    end else if (tx_fire) begin
      bus_tx_active <= next_level;
      tx_level      <= next_level;
      tx_cnt        <= next_len - 1'b1;
      tx_busy       <= 1'b1;
    end else if (tx_busy) begin
      tx_busy <= tx_cnt != '0;
      tx_cnt  <= tx_cnt - 1'b1;
    end else begin
      // Nothing queued: go passive, so a stalled host never makes a BREAK;
      // the gap only stretches the adjoining passive bit [R22]
      bus_tx_active <= 1'b0;
    end
  end

  // BREAK never sent; one seen during a send halts it [R22]
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) tx_halted <= 1'b0;
    else if (hit_break && tx_busy) tx_halted <= 1'b1;
    else if (tx_abort) tx_halted <= 1'b0;
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) eof_armed <= 1'b0;
    else if (eof_seen) eof_armed <= 1'b1;
    else if (tm.edge_seen) eof_armed <= 1'b0;
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      tx_ready   <= 1'b0;
      tx_pending <= 1'b0;
    end else begin
      tx_ready   <= !tx_busy && !tx_fire && !tx_halted;
      tx_pending <= tx_valid && !tx_fire;
    end
  end

  // Break reported once, as VPWC_SYM_BREAK, for the host to treat as an error [R23]
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      rx_valid <= 1'b0;
      rx_sym   <= VPWC_SYM_NONE;
      bus_idle <= 1'b1;
    end else begin
      rx_valid <= (tm.edge_seen && !(done_active && n > LE)) ||
                  hit_break || hit_idle;
      rx_sym   <= hit_break ? VPWC_SYM_BREAK :
                  hit_idle ? VPWC_SYM_IDLE :
                  tm.edge_seen ? edge_sym : rx_sym;
      bus_idle <= tm.edge_seen ? 1'b0 : (hit_idle ? 1'b1 : bus_idle);
    end
  end

  a_break_halts: assert property (@(posedge clk) disable iff (!rstn)
    hit_break && tx_busy |=> tx_halted) // [R22]
    else $error("break did not halt transmit");
  a_idle_flag: assert property (@(posedge clk) disable iff (!rstn)
    hit_idle |=> bus_idle && rx_sym == VPWC_SYM_IDLE) // [R12]
    else $error("idle not flagged");
  a_break_report: assert property (@(posedge clk) disable iff (!rstn)
    hit_break |=> rx_valid && rx_sym == VPWC_SYM_BREAK) // [R17]
    else $error("break not reported");
  a_sof_level: assert property (@(posedge clk) disable iff (!rstn)
    tx_fire && is_sof |=> bus_tx_active) // [R8]
    else $error("sof not active");
  a_eod_level: assert property (@(posedge clk) disable iff (!rstn)
    tx_fire && tx_kind == VPWC_TX_EOD |=> !bus_tx_active) // [R9]
    else $error("eod not passive");
  a_bit_toggle: assert property (@(posedge clk) disable iff (!rstn)
    tx_fire && tx_kind inside {VPWC_TX_DATA0, VPWC_TX_DATA1}
    |=> bus_tx_active != $past(tx_level)) // [R1]
    else $error("bit did not toggle level");
  a_short_len: assert property (@(posedge clk) disable iff (!rstn)
    tx_fire && !is_sof && next_len == CNT_W'(SHORT_CYC)
    |=> tx_busy [*8]) // [R2]
    else $error("short symbol ended early");
  a_sof_wait: assert property (@(posedge clk) disable iff (!rstn)
    tx_fire && is_sof |-> (bus_idle || (!was_active && n >= LD))) // [R19]
    else $error("sof sent too early");
  a_tx_release: assert property (@(posedge clk) disable iff (!rstn) // [R22]
    !tx_busy && !tx_fire |=> !bus_tx_active)
    else $error("bus held active with no symbol");
  a_halt_drop: assert property (@(posedge clk) disable iff (!rstn) // [R22]
    tx_halted |=> !bus_tx_active && !tx_busy)
    else $error("halted send still driving");

  c_sof_sent: cover property (@(posedge clk) tx_fire && is_sof);
  c_break:    cover property (@(posedge clk) hit_break);
  c_idle:     cover property (@(posedge clk) hit_idle);
  c_eod_rx:   cover property (@(posedge clk)
    rx_valid && rx_sym == VPWC_SYM_EOD);
  c_eof_join: cover property (@(posedge clk)
    tx_fire && is_sof && tm.edge_seen);
endmodule : vpwc_codec

// ===== vpwc_peer_node.sv
`timescale 1ns/100ps
module vpwc_peer_node (
  input  wire logic clk,
  input  wire logic dut_tx,
  output logic      bus_rx
);
  logic peer_active = 1'b0;
  // Wired-OR bus: the active level dominates
  assign bus_rx = dut_tx | peer_active;
  // Holds one level for n cycles; lengths come from the caller
  task automatic hold(input logic lvl, input int n);
    @(posedge clk);
    #1 peer_active = lvl;
    repeat (n) @(posedge clk);
  endtask : hold
endmodule : vpwc_peer_node

// ===== vpw_symbol_codec_tb_top.sv
`timescale 1ns/100ps
module vpw_symbol_codec_tb_top;
  import vpwc_pkg::*;
  logic      clk = 1'b0;
  logic      rstn = 1'b0;
  logic      bus_rx;
  logic      bus_tx_active;
  logic      tx_valid = 1'b0;
  vpwc_txk_t tx_kind = VPWC_TX_DATA0;
  logic      tx_ready;
  logic      tx_pending;
  logic      tx_abort = 1'b0;
  logic      tx_halted;
  logic      rx_valid;
  vpwc_sym_t rx_sym;
  vpwc_sym_t last_sym = VPWC_SYM_NONE;
  logic      bus_idle;
  int        num_errors = 0;
  int        check_count = 0;
  int        cycles = 0;

  vpwc_peer_node peer (.clk(clk), .dut_tx(bus_tx_active), .bus_rx(bus_rx));
  vpwc_codec dut (
    .clk(clk), .rstn(rstn), .bus_rx(bus_rx), .bus_tx_active(bus_tx_active),
    .tx_valid(tx_valid), .tx_kind(tx_kind), .tx_ready(tx_ready),
    .tx_pending(tx_pending), .tx_abort(tx_abort), .tx_halted(tx_halted),
    .rx_valid(rx_valid), .rx_sym(rx_sym), .bus_idle(bus_idle)
  );

  initial forever #12.5 clk = ~clk;

  task automatic print_verdict;
    if (num_errors == 0 && check_count > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask : print_verdict

  // Ceiling sits about a tenth above the expected run length
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (rx_valid === 1'b1) last_sym <= rx_sym;
    if (cycles == 115000) begin
      num_errors++;
      print_verdict();
    end
  end

  task automatic check(input logic ok, input string msg);
    check_count++;
    if (ok !== 1'b1) begin
      num_errors++;
      $display("CHECK FAILED at %0t: %s", $time, msg);
    end
  endtask : check

  task automatic tx_sym(input vpwc_txk_t k, input logic lvl, input int len);
    int n;
    @(posedge clk);
    #1 tx_valid = 1'b1;
    tx_kind = k;
    @(posedge clk);
    #1 tx_valid = 1'b0;
    check(bus_tx_active === lvl, "sent level");
    n = 0;
    do begin
      @(posedge clk);
      #1 n++;
    end while (tx_ready !== 1'b1 && n < 9000);
    check(n >= len - 3 && n <= len + 3, "sent length");
  endtask : tx_sym

  task automatic t_tx_frame;
    tx_sym(VPWC_TX_SOF, 1'b1, SOF_CYC);
    tx_sym(VPWC_TX_DATA0, 1'b0, SHORT_CYC);
    tx_sym(VPWC_TX_DATA1, 1'b1, SHORT_CYC);
    tx_sym(VPWC_TX_EOD, 1'b0, EOD_CYC);
  endtask : t_tx_frame

  task automatic t_idle;
    int i;
    i = 0;
    while (bus_idle !== 1'b1 && i < 13000) begin
      @(posedge clk);
      #1 i++;
    end
    repeat (4) @(posedge clk);
    #1 check(bus_idle === 1'b1, "bus not idle");
    check(last_sym === VPWC_SYM_IDLE, "idle not reported");
  endtask : t_idle

  // Peer holds a level, flips it, and the ended interval is judged
  task automatic seg(input logic lvl, input int n, input vpwc_sym_t exp);
    int i;
    peer.hold(lvl, n);
    peer.hold(!lvl, 0);
    i = 0;
    while (rx_valid !== 1'b1 && i < 20) begin
      @(posedge clk);
      #2 i++;
    end
    check(rx_sym === exp, "received class");
  endtask : seg

  task automatic t_rx_chain;
    seg(1'b1, SOF_CYC, VPWC_SYM_SOF);
    check(bus_idle === 1'b0, "idle during frame");
    seg(1'b0, LONG_CYC, VPWC_SYM_ONE);
    seg(1'b1, SHORT_CYC, VPWC_SYM_ONE);
    seg(1'b0, SHORT_CYC, VPWC_SYM_ZERO);
    seg(1'b1, LONG_CYC, VPWC_SYM_ZERO);
    seg(1'b0, EOD_CYC, VPWC_SYM_EOD);
    seg(1'b1, 1000, VPWC_SYM_INVALID);
    seg(1'b0, LIM_F_CYC + 100, VPWC_SYM_IFS);
    seg(1'b1, SHORT_CYC, VPWC_SYM_ONE);
  endtask : t_rx_chain

  // Pending SOF joins a start edge after EOF, then meets a BREAK
  task automatic t_eof_join;
    @(posedge clk);
    #1 tx_kind = VPWC_TX_SOF;
    tx_valid = 1'b1;
    peer.hold(1'b0, 10000);
    check(tx_pending === 1'b1, "sof not held");
    check(bus_tx_active === 1'b0, "sent before edge");
    peer.hold(1'b1, 8);
    check(bus_tx_active === 1'b1, "no join on edge");
    check(last_sym === VPWC_SYM_EOF, "eof class");
    // A queued bit keeps the send live when the BREAK limit is reached
    #1 tx_kind = VPWC_TX_DATA0;
    peer.hold(1'b1, LIM_E_CYC + 50);
    check(last_sym === VPWC_SYM_BREAK, "break class");
    check(tx_halted === 1'b1, "not halted");
    check(bus_tx_active === 1'b0, "still driving");
    peer.hold(1'b0, 2);
    #1 tx_abort = 1'b1;
    tx_valid = 1'b0;
    @(posedge clk);
    #1 tx_abort = 1'b0;
    @(posedge clk);
    #1 check(tx_halted === 1'b0, "halt not cleared");
  endtask : t_eof_join

  initial begin
    repeat (10) @(posedge clk);
    #1 rstn = 1'b1;
    t_tx_frame();
    t_idle();
    t_rx_chain();
    t_eof_join();
    t_idle();
    print_verdict();
  end
endmodule : vpw_symbol_codec_tb_top
